// [pll_refclk_defines.vh]
// Purpose: offsets, field positions, reset values and encodings of the pll and reference clock block
// Assumes: 32-bit classic wishbone, word-aligned registers
// Notes: definitions only
`ifndef PLL_REFCLK_DEFINES_VH
`define PLL_REFCLK_DEFINES_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_SYS_PLL_CTRL 5'h00
`define OFS_USB_PLL_CTRL 5'h04
`define OFS_REF_CLK_CTRL 5'h08
`define OFS_REF_TRIM 5'h0C
`define OFS_CLK_ENV 5'h10

// ----------------------------------------
// pll field positions
// ----------------------------------------
`define PLL_ODIV_LSB 24
`define PLL_MULT_LSB 16
`define PLL_IDIV_LSB 8
`define PLL_ICLK_BIT 7

// usb pll reset fields
`define USB_ODIV_RST 3'h1
`define USB_MULT_RST 3'h7

// ----------------------------------------
// reference clock control fields
// ----------------------------------------
`define REF_DIV_LSB 16
`define REF_ON_BIT 15
`define REF_STOP_IN_IDLE_BIT 13
`define REF_OE_BIT 12
`define REF_RUN_IN_SLEEP_BIT 11
`define REF_SWEN_BIT 9
`define REF_ACT_BIT 8
`define REF_TRIM_LSB 23

// oscillator code for system pll as current source
`define CURRENT_OSC_SELECT_SYS_PLL 3'h1

// reference source codes
`define SRC_SYSTEM_CLOCK 4'h0
`define SRC_PERIPHERAL_BUS_CLOCK 4'h1
`define SRC_MAX 4'h8

// unlock key sequence
`define UNLOCK_KEY1 32'hAA99_6655
`define UNLOCK_KEY2 32'h5566_99AA

`endif

// [ref_divider.v]
// Purpose: fractional reference clock divider with glitch-free switch
// Assumes: source clock arrives as a synchronised level, sampled on clk_i
// Notes: output toggles every div+trim/512 source edges
`timescale 1ns/1ns
module ref_divider
#(
   parameter DIV_W = 15,
   parameter TRIM_W = 9
)
(
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // control
   input wire run_i,
   input wire src_i,
   input wire [DIV_W-1:0] div_i,
   input wire [TRIM_W-1:0] trim_i,
   input wire load_i,
   // result
   output reg ref_o,
   output reg loaded_o
);

reg [DIV_W-1:0] div_r;
reg [TRIM_W-1:0] trim_r;
reg [DIV_W-1:0] cnt_r;
reg [TRIM_W:0] acc_r;
reg src_d_r;
reg pend_r;
wire src_rise;
wire [TRIM_W:0] acc_sum;
wire [DIV_W-1:0] limit;

assign src_rise = src_i & ~src_d_r;
assign acc_sum = acc_r + {1'b0, trim_r};
// extra source edge when fractional accumulator carries
assign limit = div_r + {{(DIV_W-1){1'b0}}, acc_sum[TRIM_W]}; // R20

// ----------------------------------------
// divider core
// ----------------------------------------
always @(posedge clk_i)
begin
   if (rst_i)
   begin
      div_r <= {DIV_W{1'b0}};
      trim_r <= {TRIM_W{1'b0}};
      cnt_r <= {DIV_W{1'b0}};
      acc_r <= {(TRIM_W+1){1'b0}};
      src_d_r <= 1'b0;
      pend_r <= 1'b0;
      ref_o <= 1'b0;
      loaded_o <= 1'b0;
   end
   else
   begin
      src_d_r <= src_i;
      loaded_o <= 1'b0;
      if (load_i)
         pend_r <= 1'b1;
      if (!run_i)
      begin
         // stopped: output parked low, new values apply at once
         ref_o <= 1'b0;
         cnt_r <= {DIV_W{1'b0}};
         acc_r <= {(TRIM_W+1){1'b0}};
         if (load_i | pend_r)
         begin
            div_r <= div_i;
            trim_r <= trim_i;
            pend_r <= 1'b0;
            loaded_o <= 1'b1;
         end
      end
      else if (div_r == {DIV_W{1'b0}})
      begin
         // zero divider passes the source, trim ignored
         ref_o <= src_i; // R09 R21
         if ((load_i | pend_r) & ~src_i)
         begin
            div_r <= div_i; // R23
            trim_r <= trim_i;
            pend_r <= 1'b0;
            loaded_o <= 1'b1;
         end
      end
      else if (src_rise)
      begin
         if (cnt_r + 1'b1 >= limit)
         begin
            cnt_r <= {DIV_W{1'b0}};
            acc_r <= {1'b0, acc_sum[TRIM_W-1:0]};
            ref_o <= ~ref_o;
            // swap only at the end of the high half-period
            if ((load_i | pend_r) & ref_o)
            begin
               div_r <= div_i; // R23
               trim_r <= trim_i;
               pend_r <= 1'b0;
               loaded_o <= 1'b1;
            end
         end
         else
            cnt_r <= cnt_r + 1'b1;
      end
   end
end

endmodule

// [pll_refclk_ctrl.v]
// Purpose: pll configuration registers and reference clock generator
// Assumes: classic wishbone slave, 32-bit data, clk_i at 20 MHz
// Notes: clock sources arrive as levels and pass two flip-flops
//
// What this block does
// R01: output divider codes 0-7 divide by 1,2,4,8,16,32,64,256 on both plls
// R02: multiplier codes 0-7 select 15,16,17,18,19,20,21,24 on both plls
// R03: input divider codes 0-7 divide by 1,2,3,4,5,6,10,12 on both plls
// R04: system pll source bit picks fast rc when 1, primary oscillator when 0
// R05: with fast rc source the system pll input divider is forced to one
// R06: system pll writes refused while current oscillator code is system pll
// R07: pll control writes accepted only right after the unlock key sequence
// R08: system pll fields load from fuse values at power-on reset
// R09: 15-bit reference divider; zero passes the source straight through
// R10: enable bit turns the reference generator on and off
// R11: stop-in-idle bit halts the generator while the device idles
// R12: output enable bit drives the reference clock onto its pin
// R13: run-in-sleep bit keeps the output running during sleep
// R14: run-in-sleep ignored when source is system or peripheral bus clock
// R15: divider switch bit reads one until hardware finishes the switch
// R16: request status bit shows whether the reference request is active
// R17: software avoids writing control while enable and status differ
// R18: four-bit source select covers nine sources, rest reserved
// R19: software avoids changing source while request status is one
// R20: nine-bit trim adds n/512 to the reference divider
// R21: trim has no effect while the divider is zero
// R22: while enabled, new trim waits for the divider switch bit
// R23: new divider values apply at a clock boundary without runt pulses
// R24: reserved source code gives a stopped low output
`timescale 1ns/1ns
`include "pll_refclk_defines.vh"
module pll_refclk_ctrl
#(
   parameter DIV_W = 15,
   parameter TRIM_W = 9
)
(
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   input wire por_i,
   // wishbone slave
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [4:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   output reg [31:0] dat_o,
   output reg ack_o,
   // fuse values
   input wire [2:0] fuse_pll_out_div_i,
   input wire [2:0] fuse_pll_mult_i,
   input wire [2:0] fuse_pll_in_div_i,
   input wire fuse_pll_in_source_i,
   // device state
   input wire [2:0] current_osc_select_i,
   input wire idle_i,
   input wire sleep_i,
   // clock sources as levels
   input wire system_clock_i,
   input wire peripheral_bus_clock_i,
   input wire primary_osc_i,
   input wire fast_rc_osc_i,
   input wire low_power_rc_osc_i,
   input wire secondary_osc_i,
   input wire usb_pll_clk_i,
   input wire system_pll_clk_i,
   input wire ref_clock_input_pin_i,
   // pll settings decoded
   output reg [8:0] sys_pll_out_ratio_o,
   output reg [4:0] sys_pll_mult_ratio_o,
   output reg [3:0] sys_pll_in_ratio_o,
   output reg sys_pll_src_fast_rc_o,
   output reg [8:0] usb_pll_out_ratio_o,
   output reg [4:0] usb_pll_mult_ratio_o,
   output reg [3:0] usb_pll_in_ratio_o,
   // reference clock pin
   output reg ref_clock_output_pin_o,
   output reg ref_clock_output_pin_oe_n_o
);

// ----------------------------------------
// register state
// ----------------------------------------
reg [2:0] system_pll_odiv_r;
reg [2:0] system_pll_mult_r;
reg [2:0] system_pll_idiv_r;
reg system_pll_iclk_r;
reg [2:0] usb_pll_odiv_r;
reg [2:0] usb_pll_mult_r;
reg [2:0] usb_pll_idiv_r;
reg [DIV_W-1:0] ref_div_r;
reg [TRIM_W-1:0] ref_trim_r;
reg ref_on_r;
reg ref_stop_in_idle_r;
reg ref_oe_r;
reg ref_run_in_sleep_r;
reg ref_swen_r;
reg ref_active_r;
reg [3:0] ref_sel_r;
reg [1:0] unlock_r;
reg por_seen_r;
reg [8:0] sync1_r;
reg [8:0] sync2_r;
reg src_lvl_r;
reg idle_s1_r;
reg idle_s2_r;
reg sleep_s1_r;
reg sleep_s2_r;
reg [3:0] sel_lane;
wire [31:0] wmask;
wire [31:0] wval;
wire wr_req;
wire unlocked;
wire sys_wr_ok;
wire run_gen;
wire ref_clk;
wire loaded;
wire [8:0] src_raw;
integer i;

// ----------------------------------------
// decode tables
// ----------------------------------------
function [8:0] out_ratio;
   input [2:0] code;
   begin
      if (code == 3'h7)
         out_ratio = 9'h100; // R01
      else
         out_ratio = 9'h001 << code; // R01
   end
endfunction

function [4:0] mult_ratio;
   input [2:0] code;
   begin
      if (code == 3'h7)
         mult_ratio = 5'd24; // R02
      else
         mult_ratio = 5'd15 + {2'b00, code}; // R02
   end
endfunction

function [3:0] in_ratio;
   input [2:0] code;
   begin
      case (code) // R03
         3'h6: in_ratio = 4'd10;
         3'h7: in_ratio = 4'd12;
         default: in_ratio = {1'b0, code} + 4'd1;
      endcase
   end
endfunction

// ----------------------------------------
// input synchronisers
// ----------------------------------------
assign src_raw = {ref_clock_input_pin_i, system_pll_clk_i, usb_pll_clk_i,
   secondary_osc_i, low_power_rc_osc_i, fast_rc_osc_i, primary_osc_i,
   peripheral_bus_clock_i, system_clock_i};

always @(posedge clk_i)
begin
   if (rst_i)
   begin
      sync1_r <= 9'h000;
      sync2_r <= 9'h000;
      idle_s1_r <= 1'b0;
      idle_s2_r <= 1'b0;
      sleep_s1_r <= 1'b0;
      sleep_s2_r <= 1'b0;
      src_lvl_r <= 1'b0;
   end
   else
   begin
      sync1_r <= src_raw;
      sync2_r <= sync1_r;
      idle_s1_r <= idle_i;
      idle_s2_r <= idle_s1_r;
      sleep_s1_r <= sleep_i;
      sleep_s2_r <= sleep_s1_r;
      // reserved codes give a still low source
      if (ref_sel_r > `SRC_MAX)
         src_lvl_r <= 1'b0; // R24
      else
         src_lvl_r <= sync2_r[ref_sel_r]; // R18
   end
end

// ----------------------------------------
// bus write helpers
// ----------------------------------------
always @*
begin
   for (i = 0; i < 4; i = i + 1)
      sel_lane[i] = sel_i[i];
end

assign wmask = {{8{sel_lane[3]}}, {8{sel_lane[2]}}, {8{sel_lane[1]}}, {8{sel_lane[0]}}};
assign wval = dat_i & wmask;
assign wr_req = cyc_i & stb_i & we_i & ~ack_o;
assign unlocked = (unlock_r == 2'd2);
assign sys_wr_ok = unlocked & (current_osc_select_i != `CURRENT_OSC_SELECT_SYS_PLL); // R06 R07

// generator runs once the request is active, unless idle or sleep halts it;
// waiting for the request lets the divider pick up a value written with the enable
assign run_gen = ref_active_r
   & ~(ref_stop_in_idle_r & idle_s2_r) // R11
   & ~(sleep_s2_r & ~ref_run_in_sleep_r & (ref_sel_r != `SRC_SYSTEM_CLOCK)
       & (ref_sel_r != `SRC_PERIPHERAL_BUS_CLOCK)); // R13 R14

// ----------------------------------------
// registers and wishbone slave
// ----------------------------------------
always @(posedge clk_i)
begin
   if (rst_i)
   begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
      unlock_r <= 2'd0;
      por_seen_r <= 1'b0;
      system_pll_odiv_r <= 3'h0;
      system_pll_mult_r <= 3'h0;
      system_pll_idiv_r <= 3'h0;
      system_pll_iclk_r <= 1'b0;
      usb_pll_odiv_r <= `USB_ODIV_RST;
      usb_pll_mult_r <= `USB_MULT_RST;
      usb_pll_idiv_r <= 3'h0;
      ref_div_r <= {DIV_W{1'b0}};
      ref_trim_r <= {TRIM_W{1'b0}};
      ref_on_r <= 1'b0;
      ref_stop_in_idle_r <= 1'b0;
      ref_oe_r <= 1'b0;
      ref_run_in_sleep_r <= 1'b0;
      ref_swen_r <= 1'b0;
      ref_active_r <= 1'b0;
      ref_sel_r <= 4'h0;
   end
   else
   begin
      ack_o <= cyc_i & stb_i & ~ack_o;
      // fuse values caught once after power-on reset
      if (por_i | ~por_seen_r)
      begin
         por_seen_r <= 1'b1;
         system_pll_odiv_r <= fuse_pll_out_div_i; // R08
         system_pll_mult_r <= fuse_pll_mult_i; // R08
         system_pll_idiv_r <= fuse_pll_in_div_i; // R08
         system_pll_iclk_r <= fuse_pll_in_source_i; // R08
         usb_pll_idiv_r <= fuse_pll_in_div_i;
      end
      // request status follows the enable one cycle later
      ref_active_r <= ref_on_r; // R16
      // hardware clear of the switch bit, set by software wins
      if (loaded)
         ref_swen_r <= 1'b0; // R15
      if (wr_req)
      begin
         case (adr_i)
            `OFS_CLK_ENV:
            begin
               if (dat_i == `UNLOCK_KEY1)
                  unlock_r <= 2'd1;
               else if (dat_i == `UNLOCK_KEY2 && unlock_r == 2'd1)
                  unlock_r <= 2'd2; // R07
               else
                  unlock_r <= 2'd0;
            end
            `OFS_SYS_PLL_CTRL:
            begin
               unlock_r <= 2'd0;
               if (sys_wr_ok)
               begin
                  if (sel_lane[3])
                     system_pll_odiv_r <= wval[`PLL_ODIV_LSB+2:`PLL_ODIV_LSB];
                  if (sel_lane[2])
                     system_pll_mult_r <= wval[`PLL_MULT_LSB+2:`PLL_MULT_LSB];
                  if (sel_lane[1])
                     system_pll_idiv_r <= wval[`PLL_IDIV_LSB+2:`PLL_IDIV_LSB];
                  if (sel_lane[0])
                     system_pll_iclk_r <= wval[`PLL_ICLK_BIT];
               end
            end
            `OFS_USB_PLL_CTRL:
            begin
               unlock_r <= 2'd0;
               if (unlocked) // R07
               begin
                  if (sel_lane[3])
                     usb_pll_odiv_r <= wval[`PLL_ODIV_LSB+2:`PLL_ODIV_LSB];
                  if (sel_lane[2])
                     usb_pll_mult_r <= wval[`PLL_MULT_LSB+2:`PLL_MULT_LSB];
                  if (sel_lane[1])
                     usb_pll_idiv_r <= wval[`PLL_IDIV_LSB+2:`PLL_IDIV_LSB];
               end
            end
            `OFS_REF_CLK_CTRL:
            begin
               if (sel_lane[3])
                  ref_div_r[DIV_W-1:8] <= wval[30:24];
               if (sel_lane[2])
                  ref_div_r[7:0] <= wval[23:16];
               if (sel_lane[1])
               begin
                  ref_on_r <= wval[`REF_ON_BIT]; // R10
                  ref_stop_in_idle_r <= wval[`REF_STOP_IN_IDLE_BIT];
                  ref_oe_r <= wval[`REF_OE_BIT];
                  ref_run_in_sleep_r <= wval[`REF_RUN_IN_SLEEP_BIT];
                  if (wval[`REF_SWEN_BIT])
                     ref_swen_r <= 1'b1; // R15
               end
               if (sel_lane[0])
                  ref_sel_r <= wval[3:0];
            end
            `OFS_REF_TRIM:
            begin
               if (sel_lane[3])
                  ref_trim_r[TRIM_W-1:1] <= wval[31:24];
               if (sel_lane[2])
                  ref_trim_r[0] <= wval[`REF_TRIM_LSB];
            end
            default:
            begin
               unlock_r <= unlock_r;
            end
         endcase
      end
      // read mux, unmapped reads zero
      case (adr_i)
         `OFS_SYS_PLL_CTRL:
            dat_o <= {5'h00, system_pll_odiv_r, 5'h00, system_pll_mult_r, 5'h00, system_pll_idiv_r,
               system_pll_iclk_r, 7'h00};
         `OFS_USB_PLL_CTRL:
            dat_o <= {5'h00, usb_pll_odiv_r, 5'h00, usb_pll_mult_r, 5'h00, usb_pll_idiv_r, 8'h00};
         `OFS_REF_CLK_CTRL:
            dat_o <= {1'b0, ref_div_r, ref_on_r, 1'b0, ref_stop_in_idle_r, ref_oe_r, ref_run_in_sleep_r,
               1'b0, ref_swen_r, ref_active_r, 4'h0, ref_sel_r};
         `OFS_REF_TRIM:
            dat_o <= {ref_trim_r, 23'h00_0000};
         `OFS_CLK_ENV:
            dat_o <= {30'h0000_0000, unlock_r};
         default:
            dat_o <= 32'h0000_0000;
      endcase
   end
end

// ----------------------------------------
// divider: values load on switch request or while the request is inactive
// ----------------------------------------
ref_divider #(
   .DIV_W(DIV_W),
   .TRIM_W(TRIM_W)
) u_div (
   .clk_i(clk_i),
   .rst_i(rst_i),
   .run_i(run_gen),
   .src_i(src_lvl_r),
   .div_i(ref_div_r),
   .trim_i(ref_trim_r),
   .load_i(ref_swen_r | ~ref_active_r), // R22
   .ref_o(ref_clk),
   .loaded_o(loaded)
);

// ----------------------------------------
// pll ratio outputs and reference pin
// ----------------------------------------
always @(posedge clk_i)
begin
   if (rst_i)
   begin
      sys_pll_out_ratio_o <= 9'h001;
      sys_pll_mult_ratio_o <= 5'd15;
      sys_pll_in_ratio_o <= 4'd1;
      sys_pll_src_fast_rc_o <= 1'b0;
      usb_pll_out_ratio_o <= 9'h001;
      usb_pll_mult_ratio_o <= 5'd15;
      usb_pll_in_ratio_o <= 4'd1;
      ref_clock_output_pin_o <= 1'b0;
      ref_clock_output_pin_oe_n_o <= 1'b1;
   end
   else
   begin
      sys_pll_out_ratio_o <= out_ratio(system_pll_odiv_r); // R01
      sys_pll_mult_ratio_o <= mult_ratio(system_pll_mult_r); // R02
      sys_pll_in_ratio_o <= system_pll_iclk_r ? 4'd1 : in_ratio(system_pll_idiv_r); // R05
      sys_pll_src_fast_rc_o <= system_pll_iclk_r; // R04
      usb_pll_out_ratio_o <= out_ratio(usb_pll_odiv_r);
      usb_pll_mult_ratio_o <= mult_ratio(usb_pll_mult_r);
      usb_pll_in_ratio_o <= in_ratio(usb_pll_idiv_r);
      ref_clock_output_pin_o <= ref_clk & ref_oe_r;
      ref_clock_output_pin_oe_n_o <= ~ref_oe_r; // R12
   end
end

endmodule

// [pll_refclk_props.sv]
// Purpose: bus and decode checks on the pll and reference clock block
// Assumes: one clock, synchronous active-high reset
// Notes: watches top-level ports only
`timescale 1ns/1ns
module pll_refclk_props
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic por_i,
   // bus
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [4:0] adr_i,
   input wire logic ack_o,
   // device state
   input wire logic [2:0] current_osc_select_i,
   // decoded settings
   input wire logic [8:0] sys_pll_out_ratio_o,
   input wire logic [4:0] sys_pll_mult_ratio_o,
   input wire logic [3:0] sys_pll_in_ratio_o,
   input wire logic sys_pll_src_fast_rc_o,
   input wire logic [3:0] usb_pll_in_ratio_o,
   // reference pin
   input wire logic ref_clock_output_pin_o,
   input wire logic ref_clock_output_pin_oe_n_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // request taken this edge
   wire take = cyc_i && stb_i && !ack_o;
   // ----------------------------------------
   // bus handshake
   // ----------------------------------------
   ack_answer_a: assert property (take |=> ack_o)
      else $error("request not answered next cycle");
   ack_single_a: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   ack_cause_a: assert property (ack_o |-> $past(take))
      else $error("ack without request");
   // ----------------------------------------
   // pll decode
   // ----------------------------------------
   odiv_set_a: assert property (sys_pll_out_ratio_o inside {9'h001, 9'h002, 9'h004, 9'h008,
      9'h010, 9'h020, 9'h040, 9'h100}) else $error("output ratio outside table");
   mult_set_a: assert property (sys_pll_mult_ratio_o inside {[5'h0F:5'h15], 5'h18})
      else $error("multiplier outside table");
   idiv_set_a: assert property (usb_pll_in_ratio_o inside {[4'h1:4'h6], 4'hA, 4'hC})
      else $error("input ratio outside table");
   frc_div_one_a: assert property (sys_pll_src_fast_rc_o |-> sys_pll_in_ratio_o == 4'h1)
      else $error("fast rc source without divide by one");
   current_osc_select_refuse_a: assert property ((take && we_i && adr_i == 5'h00 && !por_i &&
      current_osc_select_i == 3'h1) |=> $stable(sys_pll_mult_ratio_o) [*3])
      else $error("system pll changed while it is the clock");
   pin_off_a: assert property ((ref_clock_output_pin_oe_n_o &&
      $past(ref_clock_output_pin_oe_n_o)) |-> !ref_clock_output_pin_o)
      else $error("pin active while not driven");
   // main scenarios
   cover property (take && we_i);
   cover property ($rose(sys_pll_src_fast_rc_o));
   cover property ($rose(ref_clock_output_pin_o));
   cover property ($fell(ref_clock_output_pin_oe_n_o));
endmodule
bind pll_refclk_ctrl pll_refclk_props props_i (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .ack_o(ack_o),
   .current_osc_select_i(current_osc_select_i), .sys_pll_out_ratio_o(sys_pll_out_ratio_o),
   .sys_pll_mult_ratio_o(sys_pll_mult_ratio_o), .sys_pll_in_ratio_o(sys_pll_in_ratio_o),
   .sys_pll_src_fast_rc_o(sys_pll_src_fast_rc_o), .usb_pll_in_ratio_o(usb_pll_in_ratio_o),
   .ref_clock_output_pin_o(ref_clock_output_pin_o),
   .ref_clock_output_pin_oe_n_o(ref_clock_output_pin_oe_n_o));

// [testbench.sv]
// Purpose: self-checking bench for the pll and reference clock block
// Assumes: classic wishbone master, 50 ns clock, sources from one counter
// Notes: edge counts allow a margin of two for synchroniser delay
`timescale 1ns/1ns
`include "pll_refclk_defines.vh"
module testbench;
   // ----------------------------------------
   // stimulus and wiring
   // ----------------------------------------
   logic clk_i = 0, rst_i = 1, por_i = 1, idle_i = 0, sleep_i = 0, cyc = 0, stb = 0, we = 0;
   logic [4:0] adr = 5'h00;
   logic [3:0] sel = 4'hF;
   logic [4:0] cnt = 5'h00;
   logic [2:0] current_osc_select = 3'h0;
   logic [31:0] wdat = 32'h0000_0000;
   logic [31:0] r;
   wire [31:0] dat_o;
   wire ack_o, pin, oe_n, sf;
   wire [8:0] so, uo;
   wire [4:0] sm, um;
   wire [3:0] si, ui;
   int mismatches = 0, compares = 0, n;
   int odv[8] = '{1, 2, 4, 8, 16, 32, 64, 256};
   int mlt[8] = '{15, 16, 17, 18, 19, 20, 21, 24};
   int idv[8] = '{1, 2, 3, 4, 5, 6, 10, 12};
   pll_refclk_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .cyc_i(cyc), .stb_i(stb),
      .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
      .fuse_pll_out_div_i(3'h3), .fuse_pll_mult_i(3'h5), .fuse_pll_in_div_i(3'h4),
      .fuse_pll_in_source_i(1'b0), .current_osc_select_i(current_osc_select), .idle_i(idle_i),
      .sleep_i(sleep_i), .system_clock_i(cnt[1]), .peripheral_bus_clock_i(cnt[2]),
      .primary_osc_i(cnt[3]), .fast_rc_osc_i(cnt[1]), .low_power_rc_osc_i(cnt[2]),
      .secondary_osc_i(cnt[3]), .usb_pll_clk_i(cnt[1]), .system_pll_clk_i(cnt[2]),
      .ref_clock_input_pin_i(cnt[3]), .sys_pll_out_ratio_o(so), .sys_pll_mult_ratio_o(sm),
      .sys_pll_in_ratio_o(si), .sys_pll_src_fast_rc_o(sf), .usb_pll_out_ratio_o(uo),
      .usb_pll_mult_ratio_o(um), .usb_pll_in_ratio_o(ui), .ref_clock_output_pin_o(pin),
      .ref_clock_output_pin_oe_n_o(oe_n));
   // clock and source counter
   initial forever #25 clk_i = ~clk_i;
   always @(posedge clk_i) cnt <= cnt + 5'h01;
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         mismatches++;
      end
   endtask
   // one classic cycle; wait ends on ack, with no timeout other than the watchdog
   task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d,
      input logic [3:0] s = 4'hF);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= s;
      adr <= a;
      wdat <= d;
      @(posedge clk_i);
      while (ack_o !== 1'b1) @(posedge clk_i);
      r = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic unlock();
      xfer(1, `OFS_CLK_ENV, `UNLOCK_KEY1);
      xfer(1, `OFS_CLK_ENV, `UNLOCK_KEY2);
   endtask
   // disable with old source, wait idle, then enable with new setting
   task automatic ref_set(input logic [31:0] v);
      xfer(0, `OFS_REF_CLK_CTRL, 0);
      xfer(1, `OFS_REF_CLK_CTRL, r & 32'hFFFF_7DFF);
      do xfer(0, `OFS_REF_CLK_CTRL, 0); while (r[8] !== 1'b0);
      xfer(1, `OFS_REF_CLK_CTRL, v);
      do xfer(0, `OFS_REF_CLK_CTRL, 0); while (r[8] !== v[15]);
      chk(r & 32'h7FFF_B80F, v & 32'h7FFF_B80F);
   endtask
   // count pin rising edges over 384 cycles
   task automatic near(input int e);
      logic p;
      n = 0;
      repeat (8) @(posedge clk_i);
      p = pin;
      repeat (384)
      begin
         @(posedge clk_i);
         if (pin === 1'b1 && p === 1'b0) n++;
         p = pin;
      end
      compares++;
      if (n < e - 2 || n > e + 2)
      begin
         $display("wrong value at %0t: %0d edges, expected %0d", $time, n, e);
         mismatches++;
      end
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_fuse();
      chk(so, 8);
      chk(sm, 20);
      chk(si, 5);
      chk(sf, 0);
      xfer(0, `OFS_SYS_PLL_CTRL, 0);
      chk(r, 32'h0305_0400);
      xfer(0, `OFS_USB_PLL_CTRL, 0);
      chk(r, 32'h0107_0400);
      chk(uo, 2);
      chk(um, 24);
   endtask
   task automatic t_codes();
      logic [2:0] c;
      for (int i = 0; i < 8; i++)
      begin
         c = i[2:0];
         unlock();
         xfer(1, `OFS_SYS_PLL_CTRL, {5'h00, c, 5'h00, c, 5'h00, c, 8'h00});
         repeat (3) @(posedge clk_i);
         chk(so, odv[i]);
         chk(sm, mlt[i]);
         chk(si, idv[i]);
      end
   endtask
   task automatic t_refuse();
      xfer(1, `OFS_SYS_PLL_CTRL, 0);
      xfer(0, `OFS_SYS_PLL_CTRL, 0);
      chk(r, 32'h0707_0700);
      current_osc_select <= `CURRENT_OSC_SELECT_SYS_PLL;
      unlock();
      xfer(1, `OFS_SYS_PLL_CTRL, 0);
      xfer(0, `OFS_SYS_PLL_CTRL, 0);
      chk(r, 32'h0707_0700);
      current_osc_select <= 3'h0;
      xfer(1, `OFS_USB_PLL_CTRL, 0);
      xfer(0, `OFS_USB_PLL_CTRL, 0);
      chk(r, 32'h0107_0400);
      xfer(1, 5'h14, 32'hFFFF_FFFF);
      xfer(0, 5'h14, 0);
      chk(r, 0);
   endtask
   task automatic t_pll_misc();
      unlock();
      xfer(1, `OFS_SYS_PLL_CTRL, 32'h0000_0780);
      repeat (3) @(posedge clk_i);
      chk(si, 1);
      chk(sf, 1);
      unlock();
      xfer(1, `OFS_USB_PLL_CTRL, 32'h0602_0300);
      repeat (3) @(posedge clk_i);
      chk(uo, 64);
      chk(um, 17);
      chk(ui, 4);
      // only the multiplier byte lane is written
      unlock();
      xfer(1, `OFS_USB_PLL_CTRL, 32'h0000_0000, 4'h4);
      repeat (3) @(posedge clk_i);
      chk(um, 15);
      chk(uo, 64);
      chk(ui, 4);
   endtask
   task automatic t_sources();
      for (int s = 0; s < 10; s++)
      begin
         ref_set(32'h0000_9000 | s);
         near((s > 8) ? 0 : 384 >> (s % 3 + 2));
      end
      ref_set(32'h0000_8000);
      chk(oe_n, 1);
      near(0);
      ref_set(32'h0000_9000);
      chk(oe_n, 0);
   endtask
   task automatic t_divider();
      ref_set(32'h0001_9000);
      near(48);
      xfer(1, `OFS_REF_TRIM, 32'h8000_0000);
      near(48);
      xfer(1, `OFS_REF_CLK_CTRL, 32'h0001_9200);
      do xfer(0, `OFS_REF_CLK_CTRL, 0); while (r[9] !== 1'b0);
      near(32);
      ref_set(32'h0000_9000);
      near(96);
   endtask
   task automatic t_power();
      ref_set(32'h0000_9003);
      sleep_i <= 1'b1;
      near(0);
      ref_set(32'h0000_9803);
      near(96);
      ref_set(32'h0000_9000);
      near(96);
      sleep_i <= 1'b0;
      ref_set(32'h0000_B003);
      idle_i <= 1'b1;
      near(0);
      ref_set(32'h0000_9003);
      near(96);
      idle_i <= 1'b0;
   endtask
   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // main sequence
   initial
   begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      por_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      t_fuse();
      t_codes();
      t_refuse();
      t_pll_misc();
      t_sources();
      t_divider();
      t_power();
      close_out();
   end
   // watchdog
   initial
   begin
      #(40000 * 50);
      mismatches++;
      close_out();
   end
endmodule
